// [rtl/calsu_pkg.sv]
package calsu_pkg;

  // ---------------------------------------------------------------
  // operand sizes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CALSU_SZ_BYTE,
    CALSU_SZ_WORD,
    CALSU_SZ_LONG
  } calsu_size_t;

  // ---------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CALSU_OP_SIGNED_DIVIDE,
    CALSU_OP_COMPARE,
    CALSU_OP_NEGATE,
    CALSU_OP_ZERO_EXTEND,
    CALSU_OP_SIGN_WIDEN,
    CALSU_OP_AND,
    CALSU_OP_OR,
    CALSU_OP_XOR,
    CALSU_OP_NOT,
    CALSU_OP_ARITH_LEFT_SHIFT,
    CALSU_OP_ARITH_RIGHT_SHIFT,
    CALSU_OP_LOGICAL_LEFT_SHIFT,
    CALSU_OP_LOGICAL_RIGHT_SHIFT,
    CALSU_OP_CIRCULAR_LEFT,
    CALSU_OP_CIRCULAR_RIGHT
  } calsu_op_t;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int CALSU_DATA_W = 32;
  localparam int CALSU_BYTE_W = 8;
  localparam int CALSU_WORD_W = 16;
  localparam int CALSU_DIV_CYCLES = 16;
  localparam logic [31:0] CALSU_RESULT_RST = 32'h0000_0000;

  // flag bit positions inside condition_flags
  localparam int CALSU_FLAG_C = 0;
  localparam int CALSU_FLAG_V = 1;
  localparam int CALSU_FLAG_Z = 2;
  localparam int CALSU_FLAG_N = 3;
  localparam logic [3:0] CALSU_FLAGS_RST = 4'h0;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } calsu_flags_t;

  typedef struct packed {
    calsu_op_t op;
    calsu_size_t size;
    logic use_imm;
    logic [31:0] dest;
    logic [31:0] source_operand;
    logic [31:0] immediate_value;
  } calsu_req_t;

  typedef struct packed {
    logic [31:0] result;
    logic write_dest;
    logic div_zero;
  } calsu_rsp_t;

endpackage

// [rtl/calsu_shifter.sv]
`timescale 1ns/100ps
module calsu_shifter
  import calsu_pkg::*;
(
  input wire calsu_op_t op, // shift or rotate kind
  input wire calsu_size_t size, // operand size
  input wire logic [31:0] value, // operand
  output logic [31:0] result, // shifted operand
  output logic carry_out, // bit shifted out
  output logic overflow // sign changed on left arith shift
);

  logic [5:0] msb;
  logic top_bit;

  always_comb
  begin
    unique case (size)
      CALSU_SZ_BYTE: msb = 6'h07;
      CALSU_SZ_WORD: msb = 6'h0F;
      default: msb = 6'h1F;
    endcase
  end

  assign top_bit = value[msb[4:0]];

  // one-bit move per operation
  always_comb
  begin
    result = 32'h0000_0000;
    carry_out = 1'b0;
    overflow = 1'b0;
    unique case (op)
      CALSU_OP_ARITH_LEFT_SHIFT:
      begin
        result = {value[30:0], 1'b0}; // see RQ10
        carry_out = top_bit; // see RQ15
        overflow = top_bit ^ value[msb[4:0] - 5'h01];
      end
      CALSU_OP_LOGICAL_LEFT_SHIFT:
      begin
        result = {value[30:0], 1'b0}; // see RQ11
        carry_out = top_bit; // see RQ15
      end
      CALSU_OP_ARITH_RIGHT_SHIFT:
      begin
        result = value >> 1;
        result[msb[4:0]] = top_bit; // see RQ10
        carry_out = value[0]; // see RQ15
      end
      CALSU_OP_LOGICAL_RIGHT_SHIFT:
      begin
        result = value >> 1;
        result[msb[4:0]] = 1'b0; // see RQ11
        carry_out = value[0]; // see RQ15
      end
      CALSU_OP_CIRCULAR_LEFT:
      begin
        result = {value[30:0], top_bit}; // see RQ12
        carry_out = top_bit; // see RQ15
      end
      CALSU_OP_CIRCULAR_RIGHT:
      begin
        result = value >> 1;
        result[msb[4:0]] = value[0]; // see RQ12
        carry_out = value[0]; // see RQ15
      end
      default:
      begin
        result = value;
      end
    endcase
  end

endmodule

// [rtl/calsu_divider.sv]
`timescale 1ns/100ps
module calsu_divider
  import calsu_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic start, // begin a division
  input wire logic word_mode, // 32/16 when high, 16/8 when low
  input wire logic [31:0] dividend, // signed dividend
  input wire logic [15:0] divisor, // signed divisor
  output logic busy, // division running
  output logic done, // one-cycle pulse on completion
  output logic [15:0] quotient_reg, // signed quotient
  output logic [15:0] remainder_reg, // signed remainder
  output logic div_zero_reg // divisor was zero
);

  logic [31:0] rem_mag_reg;
  logic [31:0] quo_mag_reg;
  logic [15:0] dsr_mag_reg;
  logic [5:0] count_reg;
  logic neg_q_reg;
  logic neg_r_reg;
  logic wmode_reg;
  logic [31:0] dvd_abs;
  logic [15:0] dsr_abs;
  logic dvd_neg;
  logic dsr_neg;
  logic [32:0] trial;
  logic [31:0] shifted;

  // magnitudes of the selected-size operands
  always_comb
  begin
    if (word_mode)
    begin
      dvd_neg = dividend[31];
      dsr_neg = divisor[15];
      dvd_abs = dvd_neg ? 32'(-dividend) : dividend;
      dsr_abs = dsr_neg ? 16'(-divisor) : divisor;
    end
    else
    begin
      dvd_neg = dividend[15];
      dsr_neg = divisor[7];
      dvd_abs = {16'h0000, dvd_neg ? 16'(-dividend[15:0]) : dividend[15:0]};
      dsr_abs = {8'h00, dsr_neg ? 8'(-divisor[7:0]) : divisor[7:0]};
    end
  end

  // restoring division, one quotient bit per cycle
  assign shifted = {rem_mag_reg[30:0], quo_mag_reg[31]};
  assign trial = {1'b0, shifted} - {17'h0_0000, dsr_mag_reg};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rem_mag_reg <= 32'h0000_0000;
      quo_mag_reg <= 32'h0000_0000;
      dsr_mag_reg <= 16'h0000;
      count_reg <= 6'h00;
      busy <= 1'b0;
      neg_q_reg <= 1'b0;
      neg_r_reg <= 1'b0;
      wmode_reg <= 1'b0;
    end
    else if (start && !busy)
    begin
      rem_mag_reg <= 32'h0000_0000;
      quo_mag_reg <= word_mode ? dvd_abs : {dvd_abs[15:0], 16'h0000};
      dsr_mag_reg <= dsr_abs;
      count_reg <= word_mode ? 6'(2 * CALSU_DIV_CYCLES) : 6'(CALSU_DIV_CYCLES);
      busy <= 1'b1;
      neg_q_reg <= dvd_neg ^ dsr_neg;
      neg_r_reg <= dvd_neg;
      wmode_reg <= word_mode;
    end
    else if (busy)
    begin
      rem_mag_reg <= trial[32] ? shifted : trial[31:0];
      quo_mag_reg <= {quo_mag_reg[30:0], ~trial[32]};
      count_reg <= count_reg - 6'h01;
      busy <= (count_reg != 6'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done <= 1'b0;
      quotient_reg <= 16'h0000;
      remainder_reg <= 16'h0000;
      div_zero_reg <= 1'b0;
    end
    else
    begin
      done <= busy && (count_reg == 6'h01);
      if (start && !busy)
        div_zero_reg <= (dsr_abs == 16'h0000);
      if (busy && (count_reg == 6'h01))
      begin
        // final bit folded in here, signs applied at 16 bits for both sizes
        quotient_reg <= neg_q_reg ? 16'(-{quo_mag_reg[14:0], ~trial[32]})
                                  : {quo_mag_reg[14:0], ~trial[32]};
        remainder_reg <= neg_r_reg ? 16'(-(trial[32] ? shifted[15:0]
                                                    : trial[15:0]))
                                   : (trial[32] ? shifted[15:0]
                                                : trial[15:0]);
      end
    end
  end

endmodule

// [rtl/calsu_top.sv]
`timescale 1ns/100ps
// Overview of operation
// RQ1: signed divide 16/8 into 8-bit quotient, remainder; 32/16 into 16-bit.
// RQ2: compare subtracts source or immediate from destination; flags only.
// RQ3: negate writes zero minus destination at chosen size.
// RQ4: zero extend widens low byte or low half with zeros.
// RQ5: sign widen copies low part's top bit into all upper bits.
// RQ6: AND destination with source or immediate, write destination.
// RQ7: OR destination with source or immediate, write destination.
// RQ8: XOR destination with source or immediate, write destination.
// RQ9: NOT inverts every destination bit and writes it back.
// RQ10: arithmetic left and right shifts; right shift keeps sign.
// RQ11: logical left and right shifts fill vacated bits with zero.
// RQ12: rotates reinsert the bit shifted out at opposite end.
// RQ13: flags hold negative, zero, overflow, carry; updated by results.
// RQ14: operands are byte, word or longword register views.
// RQ15: shifts move one bit; out bit to carry; N, Z from result.
// RQ16: logic ops set N, Z, clear V, keep carry.
module calsu_top
  import calsu_pkg::*;
(
  input wire logic CLK, // 125 MHz clock
  input wire logic RESET_N, // asynchronous reset, active low
  input wire logic REQ_VALID, // operation request
  input wire calsu_req_t REQ, // operation, size and operands
  output logic REQ_READY, // unit can take a request
  output logic RSP_VALID, // one-cycle result pulse
  output calsu_rsp_t RSP, // result for destination
  output calsu_flags_t CONDITION_FLAGS // condition flag register
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // operand views
  // ---------------------------------------------------------------
  logic [31:0] src;
  logic [31:0] mask;
  logic [31:0] sign_pos;
  logic [31:0] dst_m;
  logic [31:0] src_m;
  logic take;
  logic is_div;

  assign take = REQ_VALID && REQ_READY;
  assign is_div = (REQ.op == CALSU_OP_SIGNED_DIVIDE);
  assign src = REQ.use_imm ? REQ.immediate_value : REQ.source_operand;

  always_comb
  begin
    unique case (REQ.size)
      CALSU_SZ_BYTE:
      begin
        mask = 32'h0000_00FF; // see RQ14
        sign_pos = 32'h0000_0080;
      end
      CALSU_SZ_WORD:
      begin
        mask = 32'h0000_FFFF; // see RQ14
        sign_pos = 32'h0000_8000;
      end
      default:
      begin
        mask = 32'hFFFF_FFFF; // see RQ14
        sign_pos = 32'h8000_0000;
      end
    endcase
  end

  assign dst_m = REQ.dest & mask;
  assign src_m = src & mask;

  // ---------------------------------------------------------------
  // shifter
  // ---------------------------------------------------------------
  logic [31:0] sh_result;
  logic sh_carry;
  logic sh_ovf;

  calsu_shifter u_shifter (
    .op(REQ.op),
    .size(REQ.size),
    .value(dst_m),
    .result(sh_result),
    .carry_out(sh_carry),
    .overflow(sh_ovf)
  );

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  logic div_busy;
  logic div_done;
  logic [15:0] div_quo;
  logic [15:0] div_rem;
  logic div_zero;
  logic word_div;

  assign word_div = (REQ.size != CALSU_SZ_BYTE);

  calsu_divider u_divider (
    .clk(CLK),
    .rst_n(rst_n_reg),
    .start(take && is_div),
    .word_mode(word_div),
    .dividend(REQ.dest),
    .divisor(REQ.source_operand[15:0]),
    .busy(div_busy),
    .done(div_done),
    .quotient_reg(div_quo),
    .remainder_reg(div_rem),
    .div_zero_reg(div_zero)
  );

  assign REQ_READY = !div_busy && !div_done;

  // ---------------------------------------------------------------
  // single-cycle operations
  // ---------------------------------------------------------------
  logic [32:0] diff;
  logic [31:0] res;
  logic write_en;
  calsu_flags_t flg;
  logic sub_a;
  logic sub_b;
  logic sub_r;

  // subtraction result and operand signs for compare and negate
  always_comb
  begin
    if (REQ.op == CALSU_OP_NEGATE)
      diff = {1'b0, 32'h0000_0000} - {1'b0, dst_m}; // see RQ3
    else
      diff = {1'b0, dst_m} - {1'b0, src_m}; // see RQ2
  end

  assign sub_a = (REQ.op == CALSU_OP_NEGATE) ? 1'b0 : |(dst_m & sign_pos);
  assign sub_b = (REQ.op == CALSU_OP_NEGATE) ? |(dst_m & sign_pos)
                                             : |(src_m & sign_pos);
  assign sub_r = |(diff[31:0] & sign_pos);

  always_comb
  begin
    res = REQ.dest;
    write_en = 1'b1;
    flg = CONDITION_FLAGS;
    unique case (REQ.op)
      CALSU_OP_COMPARE:
      begin
        write_en = 1'b0; // see RQ2
        flg.v = (sub_a ^ sub_b) & (sub_a ^ sub_r);
        flg.c = |((diff[32:0] ^ {1'b0, dst_m} ^ {1'b0, src_m})
                  & {sign_pos, 1'b0}); // see RQ13
      end
      CALSU_OP_NEGATE:
      begin
        res = (REQ.dest & ~mask) | (diff[31:0] & mask); // see RQ3
        flg.v = sub_b & sub_r;
        flg.c = (dst_m != 32'h0000_0000);
      end
      CALSU_OP_ZERO_EXTEND:
      begin
        res = (REQ.size == CALSU_SZ_LONG) ? {16'h0000, REQ.dest[15:0]}
              : {REQ.dest[31:16], 8'h00, REQ.dest[7:0]}; // see RQ4
        flg.v = 1'b0;
      end
      CALSU_OP_SIGN_WIDEN:
      begin
        res = (REQ.size == CALSU_SZ_LONG)
              ? {{16{REQ.dest[15]}}, REQ.dest[15:0]}
              : {REQ.dest[31:16], {8{REQ.dest[7]}}, REQ.dest[7:0]}; // see RQ5
        flg.v = 1'b0;
      end
      CALSU_OP_AND:
      begin
        res = (REQ.dest & ~mask) | (dst_m & src_m); // see RQ6
        flg.v = 1'b0; // see RQ16
      end
      CALSU_OP_OR:
      begin
        res = (REQ.dest & ~mask) | (dst_m | src_m); // see RQ7
        flg.v = 1'b0; // see RQ16
      end
      CALSU_OP_XOR:
      begin
        res = (REQ.dest & ~mask) | (dst_m ^ src_m); // see RQ8
        flg.v = 1'b0; // see RQ16
      end
      CALSU_OP_NOT:
      begin
        res = (REQ.dest & ~mask) | (~REQ.dest & mask); // see RQ9
        flg.v = 1'b0; // see RQ16
      end
      CALSU_OP_ARITH_LEFT_SHIFT,
      CALSU_OP_ARITH_RIGHT_SHIFT,
      CALSU_OP_LOGICAL_LEFT_SHIFT,
      CALSU_OP_LOGICAL_RIGHT_SHIFT,
      CALSU_OP_CIRCULAR_LEFT,
      CALSU_OP_CIRCULAR_RIGHT:
      begin
        res = (REQ.dest & ~mask) | (sh_result & mask); // see RQ10
        flg.c = sh_carry; // see RQ15
        flg.v = sh_ovf;
      end
      default:
      begin
        write_en = 1'b0;
      end
    endcase
    // n and z from the sized result; compare uses the difference
    if (REQ.op == CALSU_OP_COMPARE)
    begin
      flg.n = sub_r;
      flg.z = ((diff[31:0] & mask) == 32'h0000_0000); // see RQ13
    end
    else if (REQ.op == CALSU_OP_ZERO_EXTEND || REQ.op == CALSU_OP_SIGN_WIDEN)
    begin
      flg.n = (REQ.size == CALSU_SZ_LONG) ? res[31] : res[15];
      flg.z = (REQ.size == CALSU_SZ_LONG) ? (res == 32'h0000_0000)
              : (res[15:0] == 16'h0000);
    end
    else if (REQ.op != CALSU_OP_SIGNED_DIVIDE)
    begin
      flg.n = |(res & sign_pos); // see RQ15
      flg.z = ((res & mask) == 32'h0000_0000); // see RQ16
    end
  end

  // ---------------------------------------------------------------
  // result register
  // ---------------------------------------------------------------
  logic byte_div_reg;
  logic [31:0] div_res;

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      byte_div_reg <= 1'b0;
    else if (take && is_div)
      byte_div_reg <= !word_div;
  end

  // remainder in the upper part, quotient in the lower
  assign div_res = byte_div_reg
                   ? {RSP.result[31:16], div_rem[7:0], div_quo[7:0]}
                   : {div_rem, div_quo}; // see RQ1

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      RSP <= '{result: CALSU_RESULT_RST, write_dest: 1'b0, div_zero: 1'b0};
      RSP_VALID <= 1'b0;
    end
    else if (div_done)
    begin
      RSP <= '{result: div_res, write_dest: !div_zero, div_zero: div_zero};
      RSP_VALID <= 1'b1;
    end
    else if (take && is_div)
    begin
      RSP.result <= REQ.dest;
      RSP_VALID <= 1'b0;
    end
    else if (take)
    begin
      RSP <= '{result: res, write_dest: write_en, div_zero: 1'b0};
      RSP_VALID <= 1'b1;
    end
    else
      RSP_VALID <= 1'b0;
  end

  // ---------------------------------------------------------------
  // condition flags
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      CONDITION_FLAGS <= calsu_flags_t'(CALSU_FLAGS_RST);
    else if (div_done)
    begin
      CONDITION_FLAGS.z <= div_zero || (byte_div_reg ? div_quo[7:0] == 8'h00
                                                   : div_quo == 16'h0000);
      CONDITION_FLAGS.n <= byte_div_reg ? div_quo[7] : div_quo[15];
    end
    else if (take && !is_div)
      CONDITION_FLAGS <= flg; // see RQ13
  end

endmodule

// [test/calsu_top_asserts.sv]
`timescale 1ns/100ps
module calsu_top_asserts
  import calsu_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic RESET_N, // reset, active low
  input wire logic REQ_VALID, // request present
  input wire calsu_req_t REQ, // request fields
  input wire logic REQ_READY, // unit takes request
  input wire logic RSP_VALID, // result pulse
  input wire calsu_rsp_t RSP, // result
  input wire calsu_flags_t CONDITION_FLAGS // flags
);
  logic take;
  logic [31:0] opnd;
  assign take = REQ_VALID && REQ_READY;
  assign opnd = REQ.use_imm ? REQ.immediate_value : REQ.source_operand;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ---------------------------------------------------------------
  // divide timing
  // ---------------------------------------------------------------
  sequence div_b_s;
    take && REQ.op == CALSU_OP_SIGNED_DIVIDE && REQ.size == CALSU_SZ_BYTE
      && REQ.source_operand[7:0] != 8'h00;
  endsequence
  sequence div_w_s;
    take && REQ.op == CALSU_OP_SIGNED_DIVIDE && REQ.size == CALSU_SZ_WORD
      && REQ.source_operand[15:0] != 16'h0000;
  endsequence
  sequence quiet_s;
    (!REQ_READY && !RSP_VALID) [*8];
  endsequence
  div_byte_a: assert property (div_b_s |-> ##1 quiet_s
    ##10 RSP_VALID) else $error("byte divide result not on time");
  div_word_a: assert property (div_w_s |-> ##1 quiet_s
    ##26 RSP_VALID) else $error("word divide result not on time");
  // ---------------------------------------------------------------
  // results and flags
  // ---------------------------------------------------------------
  quick_rsp_a: assert property (take && REQ.op != CALSU_OP_SIGNED_DIVIDE
    |=> RSP_VALID) else $error("result pulse missing");
  and_res_a: assert property (take && REQ.op == CALSU_OP_AND
    |=> RSP.result[7:0] == $past(REQ.dest[7:0] & opnd[7:0]))
    else $error("and result wrong");
  or_res_a: assert property (take && REQ.op == CALSU_OP_OR
    |=> RSP.result[7:0] == $past(REQ.dest[7:0] | opnd[7:0]))
    else $error("or result wrong");
  xor_res_a: assert property (take && REQ.op == CALSU_OP_XOR
    |=> RSP.result[7:0] == $past(REQ.dest[7:0] ^ opnd[7:0]))
    else $error("xor result wrong");
  not_res_a: assert property (take && REQ.op == CALSU_OP_NOT
    |=> RSP.result[7:0] == ~$past(REQ.dest[7:0]))
    else $error("not result wrong");
  neg_res_a: assert property (take && REQ.op == CALSU_OP_NEGATE
    |=> RSP.result[7:0] == 8'h00 - $past(REQ.dest[7:0]))
    else $error("negate result wrong");
  cmp_keep_a: assert property (take && REQ.op == CALSU_OP_COMPARE
    |=> !RSP.write_dest) else $error("compare writes destination");
  logic_flag_a: assert property (take && REQ.op inside {CALSU_OP_AND,
    CALSU_OP_OR, CALSU_OP_XOR, CALSU_OP_NOT} |=> !CONDITION_FLAGS.v
    && CONDITION_FLAGS.c == $past(CONDITION_FLAGS.c))
    else $error("logic flags wrong");
  rot_left_a: assert property (take && REQ.op == CALSU_OP_CIRCULAR_LEFT
    && REQ.size == CALSU_SZ_BYTE |=> RSP.result[7:0]
    == {$past(REQ.dest[6:0]), $past(REQ.dest[7])})
    else $error("rotate left wrong");
  shr_carry_a: assert property (take
    && REQ.op == CALSU_OP_LOGICAL_RIGHT_SHIFT
    |=> CONDITION_FLAGS.c == $past(REQ.dest[0]))
    else $error("shift carry wrong");
  zext_long_a: assert property (take && REQ.op == CALSU_OP_ZERO_EXTEND
    && REQ.size == CALSU_SZ_LONG |=> RSP.result[31:16] == 16'h0000)
    else $error("zero extend upper half wrong");
endmodule
bind calsu_top calsu_top_asserts chk (.CLK(CLK), .RESET_N(RESET_N),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
  .RSP_VALID(RSP_VALID), .RSP(RSP), .CONDITION_FLAGS(CONDITION_FLAGS));

// [test/calsu_decoder_model.sv]
`timescale 1ns/100ps
module calsu_decoder_model
  import calsu_pkg::*;
(
  input wire logic clk, // clock
  input wire logic ready, // unit takes request
  output logic valid, // request present
  output calsu_req_t req // request fields
);
  initial
  begin
    valid = 1'b0;
    req = '0;
  end
  // hold request until ready seen at an edge
  task automatic send(input calsu_req_t r, output bit ok);
    int n;
    n = 0;
    valid <= 1'b1;
    req <= r;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ready !== 1'b1 && n < 200);
    ok = ready === 1'b1;
  endtask
  // released fields toggle so stale values never look valid
  task automatic idle();
    valid <= 1'b0;
    req <= calsu_req_t'(~req);
    @(posedge clk);
  endtask
endmodule

// [test/calsu_top_bench.sv]
`timescale 1ns/100ps
module calsu_top_bench
  import calsu_pkg::*;
;
  typedef struct {
    logic [31:0] res, rmask;
    logic wd, dz;
    logic [3:0] fl, fm;
  } calsu_note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid, req_ready, rsp_valid;
  calsu_req_t req, q;
  calsu_rsp_t rsp;
  calsu_flags_t flags;
  calsu_note_t notes[$];
  calsu_note_t got;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] lfsr = 32'hB6633E9F;
  logic [3:0] ef = 4'h0;
  calsu_top dut (.CLK(clk), .RESET_N(reset_n), .REQ_VALID(req_valid),
    .REQ(req), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP(rsp),
    .CONDITION_FLAGS(flags));
  calsu_decoder_model dec (.clk(clk), .ready(req_ready), .valid(req_valid),
    .req(req));
  always #4 clk = ~clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'h80200003 : 32'h0);
    return lfsr;
  endfunction
  // sign bit of every size, all ones, zero
  function automatic logic [31:0] pick();
    logic [31:0] r;
    r = rnd();
    case (r[2:0])
      3'h0: return 32'h0;
      3'h1: return 32'hFFFFFFFF;
      3'h2: return 32'h80000080;
      3'h3: return 32'h00008000;
      default: return rnd();
    endcase
  endfunction
  function automatic calsu_note_t model(calsu_req_t q, logic [3:0] f);
    calsu_note_t e;
    int w, a, b, qq, rr;
    logic [31:0] m, d, s, r, sb;
    logic c, v, full;
    w = q.size == CALSU_SZ_BYTE ? 8 : q.size == CALSU_SZ_WORD ? 16 : 32;
    m = w == 32 ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
    sb = 32'h1 << (w - 1);
    d = q.dest & m;
    s = (q.use_imm ? q.immediate_value : q.source_operand) & m;
    c = f[0];
    v = 1'b0;
    full = 1'b0;
    e.rmask = '1;
    e.wd = 1'b1;
    e.dz = 1'b0;
    e.fm = 4'hF;
    case (q.op)
      CALSU_OP_SIGNED_DIVIDE:
      begin
        a = w == 8 ? int'($signed(q.dest[15:0])) : int'($signed(q.dest));
        b = w == 8 ? int'($signed(q.source_operand[7:0]))
          : int'($signed(q.source_operand[15:0]));
        full = 1'b1;
        v = f[1];
        r = 32'h0;
        if (b == 0)
        begin
          e.dz = 1'b1;
          e.wd = 1'b0;
          e.rmask = '0;
          e.fm = 4'b0100;
        end
        else
        begin
          qq = a / b;
          rr = a % b;
          r = qq;
          e.res = w == 8 ? {q.dest[31:16], rr[7:0], qq[7:0]}
            : {rr[15:0], qq[15:0]};
        end
      end
      CALSU_OP_COMPARE:
      begin
        r = d - s;
        c = s > d;
        v = ((d ^ s) & (d ^ r) & sb) != 0;
        e.wd = 1'b0;
        e.rmask = '0;
      end
      CALSU_OP_NEGATE:
      begin
        r = 32'h0 - d;
        c = d != 0;
        v = d == sb;
      end
      CALSU_OP_ZERO_EXTEND: r = d & (m >> (w / 2));
      CALSU_OP_SIGN_WIDEN:
      begin
        r = d & (m >> (w / 2));
        if ((d & (sb >> (w / 2))) != 0)
          r = r | (m & ~(m >> (w / 2)));
      end
      CALSU_OP_AND: r = d & s;
      CALSU_OP_OR: r = d | s;
      CALSU_OP_XOR: r = d ^ s;
      CALSU_OP_NOT: r = ~d;
      CALSU_OP_ARITH_LEFT_SHIFT:
      begin
        r = d << 1;
        c = (d & sb) != 0;
        v = ((d ^ r) & sb) != 0;
      end
      CALSU_OP_ARITH_RIGHT_SHIFT:
      begin
        r = (d >> 1) | (d & sb);
        c = d[0];
      end
      CALSU_OP_LOGICAL_LEFT_SHIFT:
      begin
        r = d << 1;
        c = (d & sb) != 0;
      end
      CALSU_OP_LOGICAL_RIGHT_SHIFT:
      begin
        r = d >> 1;
        c = d[0];
      end
      CALSU_OP_CIRCULAR_LEFT:
      begin
        r = (d << 1) | 32'((d & sb) != 0);
        c = (d & sb) != 0;
      end
      default:
      begin
        r = (d >> 1) | (d[0] ? sb : 32'h0);
        c = d[0];
      end
    endcase
    r = r & m;
    if (!full)
      e.res = (q.dest & ~m) | r;
    e.fl = {(r & sb) != 0, r == 0, v, c};
    return e;
  endfunction
  task automatic issue(input calsu_req_t x);
    calsu_note_t e;
    bit ok;
    e = model(x, ef);
    ef = (e.fl & e.fm) | (ef & ~e.fm);
    notes.push_back(e);
    dec.send(x, ok);
    if (!ok)
    begin
      miscompares++;
      finish_test();
    end
    if ((rnd() & 32'h3) == 32'h0)
      dec.idle();
  endtask
  task automatic rst_chk();
    check("ready in reset", 32'(req_ready), 32'h1);
    check("pulse in reset", 32'(rsp_valid), 32'h0);
    check("flags in reset", 32'(flags), 32'(CALSU_FLAGS_RST));
    check("result in reset", rsp.result, CALSU_RESULT_RST);
  endtask
  // ---------------------------------------------------------------
  // result monitor
  // ---------------------------------------------------------------
  always @(posedge clk)
    if (rsp_valid === 1'b1)
    begin
      if (notes.size() == 0)
        check("spare result", 32'h1, 32'h0);
      else
      begin
        got = notes.pop_front();
        check("result", rsp.result & got.rmask, got.res & got.rmask);
        check("write_dest", 32'(rsp.write_dest), 32'(got.wd));
        check("div_zero", 32'(rsp.div_zero), 32'(got.dz));
        check("flags", 32'(flags & got.fm), 32'(got.fl & got.fm));
      end
    end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_chk();
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int o = 0; o < 15; o++)
      for (int k = 0; k < 12; k++)
      begin
        q.op = calsu_op_t'(o);
        q.size = calsu_size_t'(2'(rnd() % 3));
        q.use_imm = 1'(rnd());
        q.dest = pick();
        q.source_operand = pick();
        q.immediate_value = pick();
        if (o == 3 || o == 4)
          q.size = k[0] ? CALSU_SZ_LONG : CALSU_SZ_WORD;
        if (o == 0)
        begin
          q.size = k[0] ? CALSU_SZ_WORD : CALSU_SZ_BYTE;
          q.dest = k[0] ? {{16{q.dest[15]}}, q.dest[15:0]}
            : {q.dest[31:16], {8{q.dest[7]}}, q.dest[7:0]};
          if (k < 2)
            q.source_operand[15:0] = 16'h0000;
          else if (k[0] && q.source_operand[15:0] inside {16'h0, 16'hFFFF})
            q.source_operand[15:0] = 16'h0003;
          else if (!k[0] && q.source_operand[7:0] inside {8'h0, 8'hFF})
            q.source_operand[7:0] = 8'h03;
        end
        issue(q);
        if (o == 0 && k < 2)
        begin
          q.op = CALSU_OP_COMPARE;
          issue(q);
        end
      end
    dec.idle();
    for (int n = 0; n < 100 && notes.size() > 0; n++)
      @(posedge clk);
    check("pending results", 32'(notes.size()), 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_chk();
    finish_test();
  end
endmodule
